// ==== mxc_message_control.sv ====
// Control and gating for table-based message interrupts of one function.
// Assumes an Avalon-MM master on sys_clk and a message sender with a ready handshake.
`timescale 1ns/1ps
`default_nettype none
module mxc_message_control
  import mxc_pkg::*;
#(
  parameter int VECTORS = 8,
  parameter logic [10:0] TABLE_ENTRIES = 11'h008,
  parameter logic [28:0] TABLE_OFFSET = 29'h0000_0400,
  parameter logic [2:0] TABLE_BIR = 3'h0
)
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [VECTORS-1:0] vector_event,
  input wire logic legacy_request,
  output logic legacy_wire,
  output logic msg_valid,
  output logic [$clog2(VECTORS)-1:0] msg_vector,
  input wire logic msg_ready,
  output logic plain_msg_irq_active,
  output logic irq
);
  typedef enum logic [2:0] {
    MXC_IDLE = 3'b001,
    MXC_ACK = 3'b010,
    MXC_DONE = 3'b100
  } mxc_bus_state_t;

  function automatic logic [$clog2(VECTORS)-1:0] mxc_index(input logic [VECTORS-1:0] onehot);
    logic [$clog2(VECTORS)-1:0] idx;
    idx = '0;
    for (int i = 0; i < VECTORS; i++)
    begin
      if (onehot[i])
      begin
        idx = i[$clog2(VECTORS)-1:0];
      end
    end
    return idx;
  endfunction

  function automatic logic [31:0] mxc_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Table path open after an edge: table on, plain off, function unmasked
  function automatic logic mxc_path_open(input logic ten, input logic plain, input logic fmask);
    return ten & ~plain & ~fmask;
  endfunction

  mxc_bus_state_t bus_state;
  mxc_bus_state_t next_bus_state;
  logic table_irq_enable;
  logic function_wide_mask;
  logic plain_msg_irq_enable;
  logic [VECTORS-1:0] vector_mask;
  logic [VECTORS-1:0] vector_pend;
  logic [MXC_IRQ_WIDTH-1:0] irq_status;
  logic [MXC_IRQ_WIDTH-1:0] irq_mask;
  logic [15:0] sent_count;
  logic [31:0] read_word;

  mxc_vec_if #(.VECTORS(VECTORS)) vif ();

  mxc_vec_arb #(.VECTORS(VECTORS)) u_arb
  (
    .vif(vif)
  );

  // Register decode
  wire [7:0] reg_index;
  wire addr_ok;
  wire access;
  wire wr_take;
  wire rd_take;
  wire hit_control;
  wire hit_locator;
  wire hit_plain;
  wire hit_status;
  wire hit_irq_mask;
  wire hit_vec_mask;
  wire hit_pend;
  wire hit_count;
  assign addr_ok = (avs_address[1:0] == 2'h0);
  assign reg_index = avs_address[9:2];
  assign access = (bus_state == MXC_ACK);
  assign wr_take = access & avs_write & addr_ok;
  assign rd_take = access & avs_read & addr_ok;
  assign hit_control = (reg_index == MXC_IDX_MSG_CONTROL);
  assign hit_locator = (reg_index == MXC_IDX_TABLE_LOCATOR);
  assign hit_plain = (reg_index == MXC_IDX_PLAIN_CONTROL);
  assign hit_status = (reg_index == MXC_IDX_IRQ_STATUS);
  assign hit_irq_mask = (reg_index == MXC_IDX_IRQ_MASK);
  assign hit_vec_mask = (reg_index == MXC_IDX_VECTOR_MASK);
  assign hit_pend = (reg_index == MXC_IDX_VECTOR_PEND);
  assign hit_count = (reg_index == MXC_IDX_SENT_COUNT);

  // Read views
  wire [15:0] control_view;
  wire [31:0] locator_view;
  wire [31:0] merged;
  wire [31:0] vec_mask_word;
  assign control_view = {table_irq_enable, function_wide_mask, 3'h0, TABLE_ENTRIES - 11'h001};
  assign locator_view = {TABLE_OFFSET, TABLE_BIR};
  assign merged = mxc_merge(32'({vector_mask}), avs_writedata, avs_byteenable);
  assign vec_mask_word = 32'(vector_mask);

  always_comb
  begin
    read_word = MXC_READ_ZERO;
    if (addr_ok)
    begin
      if (hit_control)
        read_word = {16'h0000, control_view};
      else if (hit_locator)
        read_word = locator_view;
      else if (hit_plain)
        read_word = {31'h0, plain_msg_irq_enable};
      else if (hit_status)
        read_word = {30'h0, irq_status};
      else if (hit_irq_mask)
        read_word = {30'h0, irq_mask};
      else if (hit_vec_mask)
        read_word = vec_mask_word;
      else if (hit_pend)
        read_word = 32'(vector_pend);
      else if (hit_count)
        read_word = {16'h0000, sent_count};
    end
  end

  // One wait cycle, answer on the second edge
  always_comb
  begin
    next_bus_state = bus_state;
    case (bus_state)
      MXC_IDLE:
        if (avs_read | avs_write)
          next_bus_state = MXC_ACK;
      MXC_ACK:
        next_bus_state = MXC_DONE;
      MXC_DONE:
        next_bus_state = MXC_IDLE;
      default:
        next_bus_state = MXC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      bus_state <= MXC_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= MXC_READ_ZERO;
    end
    else
    begin
      bus_state <= next_bus_state;
      avs_waitrequest <= ~(next_bus_state == MXC_ACK);
      if (next_bus_state == MXC_ACK)
        avs_readdata <= read_word;
    end
  end

  // Gate: table on, plain off
  wire table_path_on;
  wire sending;
  wire [VECTORS-1:0] sent_bit;
  wire blocked_event;
  assign table_path_on = table_irq_enable & ~plain_msg_irq_enable;
  assign vif.pend = vector_pend;
  assign vif.vec_mask = vector_mask;
  assign vif.allow = table_path_on;
  assign vif.func_mask = function_wide_mask;
  assign sending = msg_valid & msg_ready;
  assign sent_bit = sending ? (VECTORS'(1) << msg_vector) : '0;
  assign blocked_event = |(vector_event & vector_mask) | (function_wide_mask & (|vector_event));

  // Gate as it stands after this edge
  // Held message withdrawn on close; pending bit kept
  wire ctl_write;
  wire plain_write;
  wire mask_write;
  wire next_table_irq_enable;
  wire next_function_wide_mask;
  wire next_plain_msg_irq_enable;
  wire [VECTORS-1:0] next_vector_mask;
  wire next_path_open;
  wire held_still_open;
  wire grant_still_open;

  assign ctl_write = wr_take & hit_control & avs_byteenable[1];
  assign plain_write = wr_take & hit_plain & avs_byteenable[0];
  assign mask_write = wr_take & hit_vec_mask;
  assign next_table_irq_enable = ctl_write ? avs_writedata[MXC_BIT_ENABLE] : table_irq_enable;
  assign next_function_wide_mask = ctl_write ? avs_writedata[MXC_BIT_FUNC_MASK] : function_wide_mask;
  assign next_plain_msg_irq_enable = plain_write ? avs_writedata[MXC_BIT_PLAIN_ENABLE] : plain_msg_irq_enable;
  assign next_vector_mask = mask_write ? merged[VECTORS-1:0] : vector_mask;
  assign next_path_open = mxc_path_open(next_table_irq_enable, next_plain_msg_irq_enable,
    next_function_wide_mask);
  assign held_still_open = next_path_open & ~next_vector_mask[msg_vector];
  assign grant_still_open = next_path_open & (|(vif.grant & ~next_vector_mask));

  // Control bits; function mask write touches no vector mask
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      table_irq_enable <= MXC_CONTROL_RESET[MXC_BIT_ENABLE];
      function_wide_mask <= MXC_CONTROL_RESET[MXC_BIT_FUNC_MASK];
      plain_msg_irq_enable <= 1'b0;
      irq_mask <= MXC_IRQ_RESET;
    end
    else if (wr_take)
    begin
      if (hit_control & avs_byteenable[1])
      begin
        table_irq_enable <= avs_writedata[MXC_BIT_ENABLE];
        function_wide_mask <= avs_writedata[MXC_BIT_FUNC_MASK];
      end
      if (hit_plain & avs_byteenable[0])
        plain_msg_irq_enable <= avs_writedata[MXC_BIT_PLAIN_ENABLE];
      if (hit_irq_mask & avs_byteenable[0])
        irq_mask <= avs_writedata[MXC_IRQ_WIDTH-1:0];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      vector_mask <= '0;
    else if (wr_take & hit_vec_mask)
      vector_mask <= merged[VECTORS-1:0];
  end

  // Pending held while masked or disabled; a new event beats a send
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      vector_pend <= '0;
    else
      vector_pend <= (vector_pend & ~sent_bit) | vector_event;
  end

  // Message output, held until the sender takes it
  // or withdrawn when the gate closes under it
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      msg_valid <= 1'b0;
      msg_vector <= '0;
    end
    else if (!msg_valid | msg_ready)
    begin
      msg_valid <= vif.any & ~sending & grant_still_open;
      msg_vector <= mxc_index(vif.grant);
    end
    else if (!held_still_open)
      msg_valid <= 1'b0;
  end

  // Sent counter for software
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      sent_count <= 16'h0000;
    else if (sending)
      sent_count <= sent_count + 16'h0001;
  end

  // Legacy wire and plain mode flag
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      legacy_wire <= 1'b0;
      plain_msg_irq_active <= 1'b0;
    end
    else
    begin
      legacy_wire <= legacy_request & ~table_irq_enable & ~plain_msg_irq_enable;
      plain_msg_irq_active <= plain_msg_irq_enable;
    end
  end

  // Sticky status, cleared by read; a new event wins
  wire [MXC_IRQ_WIDTH-1:0] status_set;
  wire status_clear;
  wire [MXC_IRQ_WIDTH-1:0] read_bits;
  wire [MXC_IRQ_WIDTH-1:0] next_irq_status;

  assign status_set = {blocked_event, sending};
  assign status_clear = rd_take & hit_status;
  // Clear only bits the read returned; one set under the read survives
  assign read_bits = status_clear ? avs_readdata[MXC_IRQ_WIDTH-1:0] : MXC_IRQ_RESET;
  assign next_irq_status = (irq_status & ~read_bits) | status_set;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      irq_status <= MXC_IRQ_RESET;
      irq <= 1'b0;
    end
    else
    begin
      irq_status <= next_irq_status;
      irq <= |(next_irq_status & irq_mask);
    end
  end
endmodule
`default_nettype wire

// ==== mxc_message_control_monitor.sv ====
// Port checker for the message control block.
// Assumes it is bound to the top module with its parameters.
`timescale 1ns/1ps
`default_nettype none
module mxc_message_control_monitor
  import mxc_pkg::*;
#(
  parameter int VECTORS = 8,
  parameter logic [10:0] TABLE_ENTRIES = 11'h008,
  parameter logic [28:0] TABLE_OFFSET = 29'h0000_0400,
  parameter logic [2:0] TABLE_BIR = 3'h0
)
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic legacy_request,
  input wire logic legacy_wire,
  input wire logic msg_valid,
  input wire logic [$clog2(VECTORS)-1:0] msg_vector,
  input wire logic msg_ready,
  input wire logic plain_msg_irq_active
);
  logic ten;
  logic fm;
  wire ack = !avs_waitrequest;
  wire at_ctl = avs_address == {MXC_IDX_MSG_CONTROL, 2'h0};
  wire at_loc = avs_address == {MXC_IDX_TABLE_LOCATOR, 2'h0};
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      ten <= 1'b0;
      fm <= 1'b0;
    end
    else if (avs_write && ack && at_ctl && avs_byteenable[1])
    begin
      ten <= avs_writedata[15];
      fm <= avs_writedata[14];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  a_no_wire_enabled: assert property (legacy_wire |-> !$past(ten))
    else $error("legacy wire while table enabled");
  a_wire_follows_req: assert property ((legacy_request && !ten && !plain_msg_irq_active)[*2] |-> legacy_wire)
    else $error("legacy wire missing");
  a_off_no_msg: assert property ($rose(msg_valid) |-> $past(ten))
    else $error("message while table disabled");
  a_fmask_no_msg: assert property ($rose(msg_valid) |-> !$past(fm))
    else $error("message while function masked");
  a_plain_no_msg: assert property (plain_msg_irq_active[*2] |-> !$rose(msg_valid))
    else $error("message while plain mode on");
  a_size_field_read: assert property (avs_read && ack && at_ctl |->
    avs_readdata == {16'h0, ten, fm, 3'h0, TABLE_ENTRIES - 11'h001})
    else $error("control read wrong");
  a_locator_read: assert property (avs_read && ack && at_loc |-> avs_readdata == {TABLE_OFFSET, TABLE_BIR})
    else $error("locator read wrong");
  a_msg_held: assert property (msg_valid && !msg_ready && !(avs_write && ack) |=>
    msg_valid && $stable(msg_vector))
    else $error("message dropped before ready");
  a_valid_gate_open: assert property (msg_valid |-> ten && !fm)
    else $error("message offered while gate closed");
  a_off_withdraws: assert property (avs_write && ack && at_ctl && avs_byteenable[1] && !avs_writedata[15] |=>
    !msg_valid)
    else $error("message kept after table disable");
  a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_answer_bound: assert property ((avs_read || avs_write) |-> ##[0:3] !avs_waitrequest)
    else $error("bus access not answered");
  c_send: cover property ($rose(msg_valid));
  c_wire: cover property ($rose(legacy_wire));
  c_read: cover property (avs_read && ack);
  c_withdraw: cover property (msg_valid && !msg_ready && avs_write && ack);
endmodule
`default_nettype wire

// ==== mxc_pkg.sv ====
// Package for the table-based message interrupt control block.
// Assumes a 32-bit Avalon-MM register bus with word-aligned byte addresses.
package mxc_pkg;
  // Printed offsets are not all multiples of four: they are indices, byte address = 4 * index
  localparam logic [7:0] MXC_IDX_MSG_CONTROL = 8'h02;
  localparam logic [7:0] MXC_IDX_TABLE_LOCATOR = 8'h04;
  localparam logic [7:0] MXC_IDX_PLAIN_CONTROL = 8'h08;
  localparam logic [7:0] MXC_IDX_IRQ_STATUS = 8'h09;
  localparam logic [7:0] MXC_IDX_IRQ_MASK = 8'h0a;
  localparam logic [7:0] MXC_IDX_VECTOR_MASK = 8'h0b;
  localparam logic [7:0] MXC_IDX_VECTOR_PEND = 8'h0c;
  localparam logic [7:0] MXC_IDX_SENT_COUNT = 8'h0d;
  localparam logic [31:0] MXC_READ_ZERO = 32'h0000_0000;
  // Message control field positions
  localparam int MXC_BIT_ENABLE = 15;
  localparam int MXC_BIT_FUNC_MASK = 14;
  localparam int MXC_SIZE_MSB = 10;
  // Table locator layout: offset in 31:3, indicator in 2:0
  localparam int MXC_OFFSET_LSB = 3;
  localparam int MXC_BIR_MSB = 2;
  // Plain message enable position in its own register
  localparam int MXC_BIT_PLAIN_ENABLE = 0;
  // Interrupt status bits
  localparam int MXC_IRQ_SENT = 0;
  localparam int MXC_IRQ_BLOCKED = 1;
  localparam int MXC_IRQ_WIDTH = 2;
  localparam logic [MXC_IRQ_WIDTH-1:0] MXC_IRQ_RESET = 2'h0;
  localparam logic [15:0] MXC_CONTROL_RESET = 16'h0000;
endpackage

// ==== mxc_sender_model.sv ====
// Message sender model facing the block's message port.
// Assumes valid/ready transfers on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module mxc_sender_model
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic slow,
  input wire logic msg_valid,
  input wire logic [2:0] msg_vector,
  output logic msg_ready,
  output int sends,
  output logic [2:0] last_vec
);
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      msg_ready <= 1'b0;
      sends <= 0;
      last_vec <= 3'h0;
    end
    else
    begin
      // Stalls at random when slow
      msg_ready <= slow ? 1'($urandom_range(1)) : 1'b1;
      if (msg_valid && msg_ready)
      begin
        sends <= sends + 1;
        last_vec <= msg_vector;
      end
    end
  end
endmodule
`default_nettype wire

// ==== mxc_vec_arb.sv ====
// Picks the lowest eligible pending vector for a message.
// Assumes the control block holds its pending bits until the granted message is sent.
`timescale 1ns/1ps
`default_nettype none
module mxc_vec_arb
  import mxc_pkg::*;
#(
  parameter int VECTORS = 8
)
(
  mxc_vec_if.arb vif
);
  wire [VECTORS-1:0] eligible;
  // Function mask overrides every vector mask, else own mask and the allow gate
  assign eligible = vif.pend & ~vif.vec_mask & {VECTORS{vif.allow & ~vif.func_mask}};
  // Lowest set bit
  assign vif.grant = eligible & (~eligible + {{(VECTORS-1){1'b0}}, 1'b1});
  assign vif.any = |eligible;
endmodule
`default_nettype wire

// ==== mxc_vec_if.sv ====
// Interface carrying the vector gate between the control block and its arbiter.
// Assumes both ends are on sys_clk.
`timescale 1ns/1ps
`default_nettype none
interface mxc_vec_if #(parameter int VECTORS = 8);
  logic [VECTORS-1:0] pend;
  logic [VECTORS-1:0] vec_mask;
  logic allow;
  logic func_mask;
  logic [VECTORS-1:0] grant;
  logic any;
  modport ctrl (output pend, output vec_mask, output allow, output func_mask, input grant, input any);
  modport arb (input pend, input vec_mask, input allow, input func_mask, output grant, output any);
endinterface
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the message control block.
// Assumes the sender model and the monitor compile first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mxc_pkg::*;
  localparam logic [10:0] ENT = 11'h008;
  localparam logic [28:0] OFS = 29'h0000_0400;
  localparam logic [2:0] BASE_REGISTER_INDICATOR = 3'h5;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [9:0] adr = 10'h000;
  logic rd_r = 1'b0;
  logic wr_r = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'h0;
  logic [7:0] ev = 8'h00;
  logic lreq = 1'b0;
  logic slow = 1'b0;
  logic [31:0] rdata, r;
  logic wrq, lwire, mval, mrdy, pact, irq;
  logic [2:0] mvec, lastv, v;
  int failures = 0;
  int n_checks = 0;
  int sends;
  mxc_message_control #(.TABLE_ENTRIES(ENT), .TABLE_OFFSET(OFS), .TABLE_BIR(BASE_REGISTER_INDICATOR)) u_mxc_message_control (
    .sys_clk(sys_clk), .srst(srst), .avs_address(adr), .avs_read(rd_r), .avs_write(wr_r),
    .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wrq),
    .vector_event(ev), .legacy_request(lreq), .legacy_wire(lwire), .msg_valid(mval),
    .msg_vector(mvec), .msg_ready(mrdy), .plain_msg_irq_active(pact), .irq(irq));
  mxc_sender_model u_mxc_sender_model (.sys_clk(sys_clk), .srst(srst), .slow(slow), .msg_valid(mval),
    .msg_vector(mvec), .msg_ready(mrdy), .sends(sends), .last_vec(lastv));
  always #25 sys_clk = ~sys_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d, input logic [3:0] b);
    @(posedge sys_clk);
    rd_r <= !w;
    wr_r <= w;
    adr <= {idx, 2'h0};
    wd <= d;
    be <= b;
    do
    begin
      @(posedge sys_clk);
    end
    while (wrq !== 1'b0);
    r = rdata;
    rd_r <= 1'b0;
    wr_r <= 1'b0;
  endtask
  task automatic fire(input logic [2:0] x);
    @(posedge sys_clk);
    ev <= 8'h01 << x;
    @(posedge sys_clk);
    ev <= 8'h00;
  endtask
  task automatic idle(input int n0);
    repeat (10) @(posedge sys_clk);
    chk(sends, n0);
  endtask
  task automatic expect_send(input int n0, input logic [2:0] x);
    int k;
    k = 0;
    while (sends == n0 && k < 40)
    begin
      @(posedge sys_clk);
      k++;
    end
    chk(sends, n0 + 1);
    chk(lastv, x);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    void'($urandom(37));
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    bus(1'b0, MXC_IDX_MSG_CONTROL, 32'h0, 4'hf);
    chk(r, {21'h0, ENT - 11'h001});
    bus(1'b0, MXC_IDX_TABLE_LOCATOR, 32'h0, 4'hf);
    chk(r & 32'hffff_fff8, {OFS, 3'h0});
    chk(r[2:0], BASE_REGISTER_INDICATOR);
    bus(1'b0, 8'h3f, 32'h0, 4'hf);
    chk(r, 32'h0);
    $display("test registers done");
    v = 3'($urandom);
    bus(1'b1, MXC_IDX_IRQ_MASK, 32'h1, 4'hf);
    bus(1'b1, MXC_IDX_MSG_CONTROL, 32'hffff_ffff, 4'hf);
    bus(1'b0, MXC_IDX_MSG_CONTROL, 32'h0, 4'hf);
    chk(r, {16'h0, 2'h3, 3'h0, ENT - 11'h001});
    lreq <= 1'b1;
    fire(v);
    idle(0);
    chk(lwire, 1'b0);
    bus(1'b1, MXC_IDX_VECTOR_MASK, 32'h1 << v, 4'hf);
    bus(1'b1, MXC_IDX_MSG_CONTROL, 32'h8000, 4'h3);
    idle(0);
    bus(1'b0, MXC_IDX_VECTOR_MASK, 32'h0, 4'hf);
    chk(r, 32'h1 << v);
    bus(1'b1, MXC_IDX_VECTOR_MASK, 32'h0, 4'hf);
    expect_send(0, v);
    $display("test masking done");
    bus(1'b1, MXC_IDX_MSG_CONTROL, 32'h0, 4'h3);
    fire(v ^ 3'h1);
    idle(1);
    chk(lwire, 1'b1);
    bus(1'b1, MXC_IDX_PLAIN_CONTROL, 32'h1, 4'hf);
    bus(1'b1, MXC_IDX_MSG_CONTROL, 32'h8000, 4'h3);
    idle(1);
    chk(pact, 1'b1);
    chk(lwire, 1'b0);
    bus(1'b1, MXC_IDX_PLAIN_CONTROL, 32'h0, 4'hf);
    expect_send(1, v ^ 3'h1);
    lreq <= 1'b0;
    chk(irq, 1'b1);
    bus(1'b0, MXC_IDX_IRQ_STATUS, 32'h0, 4'hf);
    chk(r[MXC_IRQ_SENT], 1'b1);
    chk(r[MXC_IRQ_BLOCKED], 1'b1);
    repeat (3) @(posedge sys_clk);
    chk(irq, 1'b0);
    $display("test enables done");
    slow <= 1'b1;
    for (int i = 0; i < 30; i++)
      fire(3'($urandom));
    bus(1'b1, MXC_IDX_MSG_CONTROL, 32'h4000, 4'h3);
    @(posedge sys_clk);
    idle(sends);
    bus(1'b1, MXC_IDX_MSG_CONTROL, 32'h8000, 4'h3);
    repeat (80) @(posedge sys_clk);
    bus(1'b0, MXC_IDX_VECTOR_PEND, 32'h0, 4'hf);
    chk(r, 32'h0);
    bus(1'b0, MXC_IDX_SENT_COUNT, 32'h0, 4'hf);
    chk(r, sends);
    $display("test burst done");
    test_done();
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    test_done();
  end
endmodule
bind mxc_message_control mxc_message_control_monitor #(.VECTORS(VECTORS), .TABLE_ENTRIES(TABLE_ENTRIES),
  .TABLE_OFFSET(TABLE_OFFSET), .TABLE_BIR(TABLE_BIR)) u_mxc_message_control_monitor (
  .sys_clk(sys_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .legacy_request(legacy_request), .legacy_wire(legacy_wire),
  .msg_valid(msg_valid), .msg_vector(msg_vector), .msg_ready(msg_ready),
  .plain_msg_irq_active(plain_msg_irq_active));
`default_nettype wire
